// *** verilog/lae_exec.sv ***
// Purpose: Execute AND, AND-high, AND-immediate and branch-if-equal
// Assumes: Operand values arrive with the word, read from the register file
// Notes: One-cycle latency; all outputs registered; data and next PC held between strobes
// What this block does
// - Register-format 0x3a/0x0e writes first AND second source to dest.
// - Register AND uses two source indices and one destination index.
// - Opcode 0x2c ANDs source with immediate in upper half, low zero.
// - Opcode 0x0c ANDs source with zero-extended immediate in low half.
// - Both AND immediates are unsigned and never sign-extended.
// - Opcode 0x26 branches to PC+4+offset when equal, else PC+4.
// - Branch offset is a signed byte displacement from the next word.
// - Taken branch to a target not word aligned raises an exception.
// - Branch-if-equal holds two register indices and signed offset.
`timescale 1ns/100ps
`default_nettype none
module lae_exec
  import lae_pkg::*;
#(
  parameter int XLEN = 32 // Register width
)
(
  input wire logic ref_clk,                  // Core clock, 100 MHz
  input wire logic rst_n,                    // Asynchronous reset, low
  input wire logic instr_valid,              // Word and operands valid
  input wire logic [31:0] instr_word,        // Instruction word
  input wire logic [31:0] instr_pc,          // Address of this instruction
  input wire logic [XLEN-1:0] first_src_reg, // Value of first source
  input wire logic [XLEN-1:0] second_src_reg,// Value of second source
  output logic claim,                        // Word was one of ours
  output logic wr_en,                        // Register write strobe
  output logic [4:0] wr_idx,                 // Register written
  output logic [XLEN-1:0] wr_data,           // Value written
  output logic pc_valid,                     // Next PC is presented
  output logic [31:0] next_pc,               // Next PC after a branch
  output logic misalign_exc                  // Misaligned branch target
);

  lae_op_e op;
  logic [4:0] second_idx;
  logic [4:0] dest_reg;
  logic [15:0] immediate_field;
  logic [XLEN-1:0] hi_mask;
  logic [XLEN-1:0] lo_mask;
  logic [XLEN-1:0] result_d;
  logic [4:0] idx_d;
  logic wr_d;
  logic [31:0] seq_pc;
  logic [31:0] disp;
  logic [31:0] target;
  logic equal;
  logic taken;
  logic claim_q;
  logic wr_en_q;
  logic [4:0] wr_idx_q;
  logic [XLEN-1:0] wr_data_q;
  logic pc_valid_q;
  logic [31:0] next_pc_q;
  logic misalign_q;

  // Field split and opcode match live in the leaf decoder
  lae_decode u_decode (
    .instr_word(instr_word),
    .op(op),
    .first_idx(),
    .second_idx(second_idx),
    .dest_idx(dest_reg),
    .immediate_field(immediate_field)
  );

  // Immediate masks: both zero-filled, never sign-extended
  assign hi_mask = {immediate_field, LAE_HALF_ZERO};
  assign lo_mask = {LAE_HALF_ZERO, immediate_field};

  // Result and destination select for the three AND forms
  always_comb
  begin
    result_d = '0;
    idx_d = LAE_RST_IDX;
    wr_d = 1'b0;
    unique case (op)
      LAE_OP_AND:
      begin
        result_d = first_src_reg & second_src_reg;
        idx_d = dest_reg;
        wr_d = instr_valid;
      end
      LAE_OP_ANDHI:
      begin
        result_d = first_src_reg & hi_mask;
        idx_d = second_idx;
        wr_d = instr_valid;
      end
      LAE_OP_ANDI:
      begin
        result_d = first_src_reg & lo_mask;
        idx_d = second_idx;
        wr_d = instr_valid;
      end
      LAE_OP_BEQ, LAE_OP_NONE:
      begin
        wr_d = 1'b0;
      end
    endcase
  end

  // Branch target: offset counts from the following instruction
  assign seq_pc = instr_pc + LAE_PC_STEP;
  assign disp = {{16{immediate_field[15]}}, immediate_field};
  assign target = seq_pc + disp;
  assign equal = (first_src_reg == second_src_reg);
  assign taken = instr_valid && (op == LAE_OP_BEQ) && equal;

  // Claim pulse so the pipeline knows this unit handled the word
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      claim_q <= 1'b0;
    end
    else
    begin
      claim_q <= instr_valid && (op != LAE_OP_NONE);
    end
  end

  // Register write-back; data is held between strobes
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_en_q <= 1'b0;
      wr_idx_q <= LAE_RST_IDX;
      wr_data_q <= '0;
    end
    else
    begin
      wr_en_q <= wr_d;
      if (wr_d)
      begin
        wr_idx_q <= idx_d;
        wr_data_q <= result_d;
      end
    end
  end

  // Next PC for the equal branch, taken or not
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pc_valid_q <= 1'b0;
      next_pc_q <= LAE_RST_WORD;
    end
    else
    begin
      pc_valid_q <= instr_valid && (op == LAE_OP_BEQ);
      if (instr_valid && op == LAE_OP_BEQ)
      begin
        next_pc_q <= equal ? target : seq_pc;
      end
    end
  end

  // Only a taken branch can fault; fall-through is always aligned
  // as long as the current PC itself is aligned
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      misalign_q <= 1'b0;
    end
    else
    begin
      misalign_q <= taken && (target[1:0] != 2'b00);
    end
  end

  // Ports come straight from the flops
  assign claim = claim_q;
  assign wr_en = wr_en_q;
  assign wr_idx = wr_idx_q;
  assign wr_data = wr_data_q;
  assign pc_valid = pc_valid_q;
  assign next_pc = next_pc_q;
  assign misalign_exc = misalign_q;

  // Checks on the registered outputs
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_issue_and;
    instr_valid && op == LAE_OP_AND;
  endsequence

  sequence s_issue_beq;
    instr_valid && op == LAE_OP_BEQ;
  endsequence

  a_and_rr_result: assert property (
    s_issue_and |=> wr_en && wr_data ==
      ($past(first_src_reg) & $past(second_src_reg)))
    else $error("register AND result wrong");

  a_and_rr_dest: assert property (
    s_issue_and |=> wr_idx == $past(instr_word[21:17]))
    else $error("register AND destination wrong");

  a_andhi_result: assert property (
    instr_valid && op == LAE_OP_ANDHI |=> wr_en &&
      wr_data[15:0] == 16'h0000 &&
      wr_data[31:16] == ($past(first_src_reg[31:16]) &
        $past(instr_word[21:6])) &&
      wr_idx == $past(instr_word[26:22]))
    else $error("AND high result wrong");

  a_andi_zero_ext: assert property (
    instr_valid && op == LAE_OP_ANDI |=> wr_en &&
      wr_data == {16'h0000, $past(first_src_reg[15:0]) &
        $past(instr_word[21:6])} &&
      wr_idx == $past(instr_word[26:22]))
    else $error("AND immediate result wrong");

  a_beq_next_pc: assert property (
    s_issue_beq ##0 (first_src_reg != second_src_reg) |=>
      pc_valid && next_pc == $past(instr_pc) + 32'h0000_0004)
    else $error("untaken branch PC wrong");

  a_beq_target: assert property (
    s_issue_beq ##0 (first_src_reg == second_src_reg) |=>
      pc_valid && next_pc == $past(instr_pc) + 32'h0000_0004 +
        {{16{$past(instr_word[21])}}, $past(instr_word[21:6])})
    else $error("taken branch target wrong");

  a_misalign_raise: assert property (
    ##1 misalign_exc |-> $past(taken) && next_pc[1:0] != 2'b00)
    else $error("misalign flag without cause");

  a_misalign_seen: assert property (
    taken && target[1:0] != 2'b00 |=> misalign_exc ##1 !misalign_exc
      or (misalign_exc ##1 $past(taken)))
    else $error("misaligned target not flagged");

  a_and_no_exc: assert property (
    instr_valid && op inside {LAE_OP_AND, LAE_OP_ANDHI, LAE_OP_ANDI}
      |=> !misalign_exc && !pc_valid && claim)
    else $error("AND form raised exception");

  a_idle_quiet: assert property (
    !instr_valid |=> !wr_en && !pc_valid && !misalign_exc && !claim)
    else $error("output pulse without instruction");

endmodule // lae_exec
`default_nettype wire

// *** verilog/lae_pkg.sv ***
// Purpose: Shared constants and types for the AND / branch-if-equal unit
// Assumes: 32-bit instruction words, 32-bit registers, 32 registers
// Notes: Field positions follow the standard three-field word layout
package lae_pkg;

  // Primary and extended opcodes
  localparam logic [5:0] LAE_OPC_RTYPE = 6'h3a;
  localparam logic [5:0] LAE_OPX_AND = 6'h0e;
  localparam logic [5:0] LAE_OPC_ANDHI = 6'h2c;
  localparam logic [5:0] LAE_OPC_ANDI = 6'h0c;
  localparam logic [5:0] LAE_OPC_BEQ = 6'h26;

  // Field positions (least significant bit of each field)
  localparam int LAE_FA_LSB = 27;
  localparam int LAE_FB_LSB = 22;
  localparam int LAE_FC_LSB = 17;
  localparam int LAE_OPX_LSB = 11;
  localparam int LAE_IMM_LSB = 6;
  localparam int LAE_OPC_LSB = 0;

  // Halfword filler and sequential step
  localparam logic [15:0] LAE_HALF_ZERO = 16'h0000;
  localparam logic [31:0] LAE_PC_STEP = 32'h0000_0004;

  // Values after reset
  localparam logic [31:0] LAE_RST_WORD = 32'h0000_0000;
  localparam logic [4:0] LAE_RST_IDX = 5'h00;

  // Decoded operation
  typedef enum logic [2:0] {
    LAE_OP_NONE = 3'b000,
    LAE_OP_AND = 3'b001,
    LAE_OP_ANDHI = 3'b010,
    LAE_OP_ANDI = 3'b011,
    LAE_OP_BEQ = 3'b100
  } lae_op_e;

endpackage

// *** verilog/lae_decode.sv ***
// Purpose: Pure decode of one instruction word into operation and fields
// Assumes: Word is stable while the caller samples the outputs
// Notes: Combinational; the caller registers everything it drives out
`timescale 1ns/100ps
`default_nettype none
module lae_decode
  import lae_pkg::*;
(
  input wire logic [31:0] instr_word, // Instruction being decoded
  output lae_op_e op,                 // Recognised operation
  output logic [4:0] first_idx,       // First source register index
  output logic [4:0] second_idx,      // Second source / immediate dest index
  output logic [4:0] dest_idx,        // Register-format destination index
  output logic [15:0] immediate_field // Raw 16-bit immediate
);

  logic [5:0] opc;
  logic [5:0] opx;

  // Field extraction at fixed positions
  assign first_idx = instr_word[LAE_FA_LSB +: 5];
  assign second_idx = instr_word[LAE_FB_LSB +: 5];
  assign dest_idx = instr_word[LAE_FC_LSB +: 5];
  assign immediate_field = instr_word[LAE_IMM_LSB +: 16];
  assign opc = instr_word[LAE_OPC_LSB +: 6];
  assign opx = instr_word[LAE_OPX_LSB +: 6];

  // Opcode recognition; anything else is left to other units
  always_comb
  begin
    op = LAE_OP_NONE;
    if (opc == LAE_OPC_RTYPE && opx == LAE_OPX_AND)
    begin
      op = LAE_OP_AND;
    end
    else if (opc == LAE_OPC_ANDHI)
    begin
      op = LAE_OP_ANDHI;
    end
    else if (opc == LAE_OPC_ANDI)
    begin
      op = LAE_OP_ANDI;
    end
    else if (opc == LAE_OPC_BEQ)
    begin
      op = LAE_OP_BEQ;
    end
  end

endmodule // lae_decode
`default_nettype wire

// *** tb/lae_rf_model.sv ***
// Purpose: Register file model feeding operands to the execute unit
// Assumes: Operands are read combinationally from the word's index fields
// Notes: Writes land on the edge after the strobe; no forwarding is modelled
`timescale 1ns/100ps
`default_nettype none
module lae_rf_model
(
  input wire logic ref_clk, // Core clock
  input wire logic rst_n, // Asynchronous reset, low
  input wire logic [31:0] instr_word, // Word whose operands are read
  input wire logic wr_en, // Write strobe from the unit
  input wire logic [4:0] wr_idx, // Register written
  input wire logic [31:0] wr_data, // Value written
  output logic [31:0] first_val, // Value of the first source
  output logic [31:0] second_val // Value of the second source
);
  logic [31:0] regs_q [32];

  // Distinct preload per index, so equal values need equal indices
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 32; i++)
        regs_q[i] <= 32'ha5c3_0f96 ^ (i * 32'h0101_0101);
    end
    else if (wr_en)
    begin
      regs_q[wr_idx] <= wr_data;
    end
  end

  // Operands follow the fixed index fields of the word
  assign first_val = regs_q[instr_word[31:27]];
  assign second_val = regs_q[instr_word[26:22]];
endmodule // lae_rf_model
`default_nettype wire

// *** tb/lae_exec_tb.sv ***
// Purpose: Self-checking bench for the AND / branch-if-equal unit
// Assumes: One-cycle registered answer, operands from the register model
// Notes: Back-to-back words never read a register written just before
`timescale 1ns/100ps
`default_nettype none
module lae_exec_tb
  import lae_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n, instr_valid;
  logic [31:0] instr_word, instr_pc, first_val, second_val;
  logic claim, wr_en, pc_valid, misalign_exc;
  logic [4:0] wr_idx;
  logic [31:0] wr_data, next_pc;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] sh [32];

  lae_exec dut (.ref_clk(ref_clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_pc(instr_pc),
    .first_src_reg(first_val), .second_src_reg(second_val), .claim(claim),
    .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data), .pc_valid(pc_valid),
    .next_pc(next_pc), .misalign_exc(misalign_exc));

  lae_rf_model rf (.ref_clk(ref_clk), .rst_n(rst_n), .instr_word(instr_word),
    .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data),
    .first_val(first_val), .second_val(second_val));

  // Clock and a hang guard sized well above the short test sequence
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_fail++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] rw(input logic [4:0] a, input logic [4:0] b,
    input logic [4:0] c, input logic [5:0] x);
    return {a, b, c, x, 5'h00, LAE_OPC_RTYPE};
  endfunction

  function automatic logic [31:0] iw(input logic [4:0] a, input logic [4:0] b,
    input logic [15:0] imm, input logic [5:0] opc);
    return {a, b, imm, opc};
  endfunction

  // Present one word, let it be taken, then judge pulses {claim,wr,pc,exc}
  task automatic run(input logic [31:0] w, input logic [31:0] pc,
    input logic [3:0] fl, input logic [4:0] idx, input logic [31:0] val);
    instr_valid = 1'b1;
    instr_word = w;
    instr_pc = pc;
    @(posedge ref_clk);
    #1;
    cmp({28'h0, claim, wr_en, pc_valid, misalign_exc}, {28'h0, fl});
    if (fl[2])
    begin
      cmp({27'h0, wr_idx}, {27'h0, idx});
      cmp(wr_data, val);
      sh[idx] = val;
    end
    if (fl[1])
      cmp(next_pc, val);
  endtask

  // Word left on the bus with valid low must raise nothing
  task automatic idle();
    instr_valid = 1'b0;
    @(posedge ref_clk);
    #1;
    cmp({28'h0, claim, wr_en, pc_valid, misalign_exc}, 32'h0);
  endtask

  task automatic t_reset();
    #1;
    cmp({28'h0, claim, wr_en, pc_valid, misalign_exc}, 32'h0);
    cmp(wr_data | next_pc | {27'h0, wr_idx}, 32'h0);
    rst_n = 1'b1;
  endtask

  task automatic t_and();
    run(rw(5'd3, 5'd5, 5'd9, LAE_OPX_AND), 32'h0, 4'hc, 5'd9,
      sh[3] & sh[5]);
    run(rw(5'd7, 5'd8, 5'd10, LAE_OPX_AND), 32'h0, 4'hc, 5'd10,
      sh[7] & sh[8]);
    run(rw(5'd1, 5'd2, 5'd11, 6'h0f), 32'h0, 4'h0, 5'd0, 32'h0);
    idle();
  endtask

  task automatic t_imm();
    run(iw(5'd4, 5'd12, 16'h8001, LAE_OPC_ANDHI), 32'h0, 4'hc,
      5'd12, sh[4] & 32'h8001_0000);
    run(iw(5'd6, 5'd13, 16'hfff0, LAE_OPC_ANDI), 32'h0, 4'hc,
      5'd13, sh[6] & 32'h0000_fff0);
    run(iw(5'd6, 5'd14, 16'h0000, 6'h00), 32'h0, 4'h0, 5'd0, 32'h0);
    idle();
  endtask

  task automatic t_beq();
    run(iw(5'd2, 5'd2, 16'h0010, LAE_OPC_BEQ), 32'h1000, 4'ha,
      5'd0, 32'h0000_1014);
    run(iw(5'd3, 5'd3, 16'hfff8, LAE_OPC_BEQ), 32'h1000, 4'ha,
      5'd0, 32'h0000_0ffc);
    run(iw(5'd2, 5'd3, 16'h0010, LAE_OPC_BEQ), 32'h1000, 4'ha,
      5'd0, 32'h0000_1004);
    run(iw(5'd1, 5'd1, 16'h0002, LAE_OPC_BEQ), 32'h1000, 4'hb,
      5'd0, 32'h0000_1006);
    run(iw(5'd1, 5'd2, 16'h0002, LAE_OPC_BEQ), 32'h1000, 4'ha,
      5'd0, 32'h0000_1004);
    idle();
  endtask

  // Main sequence: reset held for 20 cycles, then each scenario in turn
  initial
  begin
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr_word = 32'h0;
    instr_pc = 32'h0;
    for (int i = 0; i < 32; i++)
      sh[i] = 32'ha5c3_0f96 ^ (i * 32'h0101_0101);
    repeat (20) @(posedge ref_clk);
    t_reset();
    t_and();
    t_imm();
    t_beq();
    complete_run();
  end
endmodule // lae_exec_tb
`default_nettype wire
